//--- logic/can_sched_pkg.sv
// shared constants and carriers for the can buffer scheduler
// assumes one hclk domain; the bit engine runs on the same clock
package can_sched_pkg;

    // register byte offsets on the ahb-lite bus
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] isr_off = 8'h04;
    localparam logic [7:0] icr_off = 8'h08;
    localparam logic [7:0] lid_hi_off = 8'h0c;
    localparam logic [7:0] lid_lo_off = 8'h10;
    localparam logic [7:0] filt0_off = 8'h14;
    localparam logic [7:0] filt1_off = 8'h18;
    localparam logic [7:0] bsr_base_off = 8'h20;
    localparam logic [7:0] ldb_base_off = 8'h30;

    // control/status bit positions
    localparam int ctrl_run_pos = 0;
    localparam int ctrl_fast_pos = 1;
    localparam int ctrl_no_retransmit_bit_pos = 2;
    localparam int ctrl_self_pos = 3;
    // flag / enable positions, shared by status and control
    localparam int flag_txd_pos = 0;
    localparam int flag_txe_pos = 1;
    localparam int flag_rx_pos = 2;
    localparam int flag_ovr_pos = 3;
    // buffer status bit positions
    localparam int bsr_claim_pos = 0;
    localparam int bsr_pend_pos = 1;
    localparam int bsr_busy_pos = 2;
    localparam int bsr_job_pos = 3;
    localparam int bsr_idx_pos = 4;
    localparam int bsr_id_pos = 16;

    // reset values
    localparam logic [3:0] ctrl_rst = 4'h0;
    localparam logic [3:0] icr_rst = 4'h0;
    localparam logic [31:0] filt_rst = 32'h0000_0000;

    // resync counts
    localparam logic [3:0] recessive_run_len = 4'd11;
    localparam logic [7:0] slow_seq_count = 8'd128;
    localparam logic [7:0] fast_seq_count = 8'd1;

    typedef enum logic [3:0] {
        st_resync = 4'b0001,
        st_idle = 4'b0010,
        st_tx = 4'b0100,
        st_frame = 4'b1000
    } sched_state_t;

    // events from the bit engine, all on hclk
    typedef struct packed {
        logic bit_tick;
        logic bit_recessive;
        logic sof_seen;
        logic frame_end;
        logic standby;
        logic bus_off;
        logic tx_ok;
        logic tx_fail;
        logic rx_valid;
        logic rx_own;
        logic [15:0] rx_id;
    } engine_evt_t;

    // requests to the bit engine
    typedef struct packed {
        logic tx_req;
        logic [1:0] tx_buf;
        logic [15:0] tx_id;
        logic [7:0] tx_byte;
        logic synced;
    } engine_req_t;
endpackage : can_sched_pkg

//--- logic/can_buffer_scheduler.sv
// can buffer scheduler: resync, idle watch, tx job ranking, rx filtering
// assumes an ahb-lite master on hclk and a bit engine on the same clock
// that reports bit samples, frame edges and tx/rx results as pulses
//
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

// How it works
// R1 - resynced only after 128 runs of 11 recessive bits
// R2 - fast resync bit and not bus-off: one run of 11 suffices
// R3 - standby or bus-off sends the node back to resync
// R4 - idle left on run cleared, start of frame, or job submission
// R5 - submission is a last data byte write to a claimed buffer
// R6 - idle bus sends highest pending job, buffer 3 first
// R7 - lost arbitration or error retries unless no-retransmit is set
// R8 - retry stops on success, unclaim, no-retransmit, bus-off, preemption
// R9 - pending flag held from submission until the job ends
// R10 - busy bit shows the buffer now on the bus
// R11 - done or error flag set, each interrupts when enabled
// R12 - self-reception enable lets own frames through the filters
// R13 - reception only after sync, every identifier filtered
// R14 - elected when masked compare matches at least one filter
// R15 - target is lowest buffer with claim and pending clear
// R16 - no free buffer raises overrun interrupt when enabled
// R17 - last identifier kept until a newer one arrives
// R18 - store id, filter index, set pending and receive flag
// R19 - each buffer keeps independent status bits
// R20 - busy clears when the bus transfer ends in any way
module can_buffer_scheduler (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire can_sched_pkg::engine_evt_t evt,
    output can_sched_pkg::engine_req_t req,
    output logic irq
);
    import can_sched_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // bus slave state
    logic wr_pend_reg;
    logic rd_pend_reg;
    logic [7:0] acc_addr_reg;
    logic [31:0] hrdata_reg;

    // control, flags, filters
    logic [3:0] ctrl_reg;
    logic [3:0] icr_reg;
    logic [3:0] isr_reg;
    logic [3:0] isr_next;
    logic [15:0] lid_reg;
    logic [31:0] filt_reg [2];

    // per-buffer status, kept apart for each buffer
    logic [2:0] claim_reg, claim_next;
    logic [2:0] pend_reg, pend_next;
    logic [2:0] job_reg, job_next;
    logic [2:0] busy_reg, busy_next;
    logic [2:0] idx_reg, idx_next;
    logic [15:0] id_reg [3];
    logic [15:0] id_next [3];
    logic [7:0] byte_reg [3];
    logic [7:0] byte_next [3];

    // scheduler state
    sched_state_t state_reg, state_next;
    logic [1:0] cur_reg;
    logic [3:0] run_reg;
    logic [7:0] seq_reg;
    logic boff_reg;

    ////////////////////////////////////////////////////////////////////
    // address phase decode; writes land in the following data phase
    wire addr_ok = hsel && htrans[1] && hready;
    wire ctrl_wr = wr_pend_reg && (acc_addr_reg == ctrl_off);
    wire isr_wr = wr_pend_reg && (acc_addr_reg == isr_off);
    wire icr_wr = wr_pend_reg && (acc_addr_reg == icr_off);
    wire filt0_wr = wr_pend_reg && (acc_addr_reg == filt0_off);
    wire filt1_wr = wr_pend_reg && (acc_addr_reg == filt1_off);
    wire [7:0] bsr_rel = acc_addr_reg - bsr_base_off;
    wire [7:0] ldb_rel = acc_addr_reg - ldb_base_off;
    wire [2:0] bsr_wr;
    wire [2:0] ldb_wr;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_dec
            assign bsr_wr[gi] = wr_pend_reg && (bsr_rel == 8'(gi * 4));
            assign ldb_wr[gi] = wr_pend_reg && (ldb_rel == 8'(gi * 4));
        end
    endgenerate

    // reads wait one cycle so a write just before is already visible
    assign hreadyout = !rd_pend_reg;
    assign hrdata = hrdata_reg;
    assign hresp = 1'b0;

    ////////////////////////////////////////////////////////////////////
    // resync bookkeeping
    wire run_bit = ctrl_reg[ctrl_run_pos];
    wire no_retransmit_bit_bit = ctrl_reg[ctrl_no_retransmit_bit_pos];
    wire lose_sync = evt.standby || evt.bus_off || !run_bit; // see R3
    wire run_full = evt.bit_tick && evt.bit_recessive
        && (run_reg == recessive_run_len - 4'd1);
    wire [7:0] seq_goal = (ctrl_reg[ctrl_fast_pos] && !boff_reg)
        ? fast_seq_count : slow_seq_count; // see R1 see R2
    wire resync_done = run_full && (seq_reg + 8'd1 >= seq_goal);

    // tx ranking: buffer 3 beats 2 beats 1
    wire [2:0] tx_cand = pend_reg & job_reg & claim_reg;
    wire tx_any = |tx_cand;
    wire [1:0] tx_sel = tx_cand[2] ? 2'd2 : (tx_cand[1] ? 2'd1 : 2'd0); // see R6

    // reception: sync, own-frame gate, filters
    wire synced = (state_reg != st_resync);
    wire rx_take = evt.rx_valid && synced
        && (!evt.rx_own || ctrl_reg[ctrl_self_pos]); // see R12 see R13
    wire hit0 = ((evt.rx_id ^ filt_reg[0][15:0]) & filt_reg[0][31:16])
        == 16'h0000;
    wire hit1 = ((evt.rx_id ^ filt_reg[1][15:0]) & filt_reg[1][31:16])
        == 16'h0000;
    wire elected = rx_take && (hit0 || hit1); // see R14
    wire hit_idx = !hit0; // lowest matching filter wins
    wire [2:0] free = ~claim_reg & ~pend_reg;
    wire [1:0] rx_tgt = free[0] ? 2'd0 : (free[1] ? 2'd1 : 2'd2); // see R15
    wire rx_store = elected && (|free);
    wire rx_ovr = elected && !(|free); // see R16

    // transmit outcome for the buffer on the bus
    wire in_tx = (state_reg == st_tx);
    wire tx_end_ok = in_tx && evt.tx_ok;
    wire tx_end_err = in_tx && evt.tx_fail;
    wire tx_start = (state_reg == st_idle) && !lose_sync
        && !evt.sof_seen && tx_any;
    wire tx_drop = in_tx && lose_sync;

    ////////////////////////////////////////////////////////////////////
    // state transitions
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            st_resync: begin
                if (!lose_sync && resync_done) begin
                    state_next = st_idle; // see R1 see R2
                end
            end
            st_idle: begin
                if (lose_sync) begin
                    state_next = st_resync; // see R4
                end else if (evt.sof_seen) begin
                    state_next = st_frame; // see R4
                end else if (tx_any) begin
                    state_next = st_tx; // see R4 see R5
                end
            end
            st_tx: begin
                if (lose_sync) begin
                    state_next = st_resync; // see R3
                end else if (evt.tx_ok || evt.tx_fail) begin
                    // back to idle re-ranks, so a higher job preempts
                    state_next = st_idle; // see R7 see R8
                end
            end
            st_frame: begin
                if (lose_sync) begin
                    state_next = st_resync; // see R3
                end else if (evt.frame_end) begin
                    state_next = st_idle;
                end
            end
            default: state_next = st_resync;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // per-buffer next values; later lines take precedence
    always_comb begin
        claim_next = claim_reg;
        pend_next = pend_reg;
        job_next = job_reg;
        busy_next = busy_reg;
        idx_next = idx_reg;
        for (int i = 0; i < 3; i++) begin
            id_next[i] = id_reg[i];
            byte_next[i] = byte_reg[i];
            if (bsr_wr[i]) begin
                claim_next[i] = hwdata[bsr_claim_pos];
                id_next[i] = hwdata[bsr_id_pos +: 16];
                // releasing a received message frees the buffer
                if (hwdata[bsr_pend_pos] && !job_reg[i]) begin
                    pend_next[i] = 1'b0;
                end
                // unclaiming cancels any tx job outright
                if (!hwdata[bsr_claim_pos] && job_reg[i]) begin
                    pend_next[i] = 1'b0; // see R8
                    job_next[i] = 1'b0;
                end
            end
            if (ldb_wr[i]) begin
                byte_next[i] = hwdata[7:0];
                if (claim_reg[i]) begin
                    pend_next[i] = 1'b1; // see R5 see R9
                    job_next[i] = 1'b1;
                end
            end
            if (tx_start && tx_sel == 2'(i)) begin
                busy_next[i] = 1'b1; // see R10
            end
            if ((tx_end_ok || tx_end_err || tx_drop) && cur_reg == 2'(i)) begin
                busy_next[i] = 1'b0; // see R20
                if (tx_end_ok || (tx_end_err && no_retransmit_bit_bit)) begin
                    pend_next[i] = 1'b0; // see R9 see R8
                    job_next[i] = 1'b0;
                end
            end
            if (evt.bus_off && job_reg[i]) begin
                pend_next[i] = 1'b0; // see R8
                job_next[i] = 1'b0;
            end
            if (rx_store && rx_tgt == 2'(i)) begin
                id_next[i] = evt.rx_id; // see R18 see R19
                idx_next[i] = hit_idx;
                pend_next[i] = 1'b1;
                job_next[i] = 1'b0;
            end
        end
    end

    // sticky flags: a hardware set beats a software clear
    always_comb begin
        isr_next = isr_reg;
        if (isr_wr) begin
            isr_next = isr_reg & ~hwdata[3:0];
        end
        if (tx_end_ok) begin
            isr_next[flag_txd_pos] = 1'b1; // see R11
        end
        if (tx_end_err) begin
            isr_next[flag_txe_pos] = 1'b1; // see R11
        end
        if (rx_store) begin
            isr_next[flag_rx_pos] = 1'b1; // see R18
        end
        if (rx_ovr) begin
            isr_next[flag_ovr_pos] = 1'b1; // see R16
        end
    end

    // one shared line for all flags, each gated by its own enable
    assign irq = |(isr_reg & icr_reg); // see R11 see R16 see R18

    ////////////////////////////////////////////////////////////////////
    // read mux, sampled in the wait cycle of a read
    logic [31:0] rd_mux;
    always_comb begin
        case (acc_addr_reg)
            ctrl_off: rd_mux = {26'h0, boff_reg, synced, ctrl_reg};
            isr_off: rd_mux = {28'h0, isr_reg};
            icr_off: rd_mux = {28'h0, icr_reg};
            lid_hi_off: rd_mux = {24'h0, lid_reg[15:8]}; // see R17
            lid_lo_off: rd_mux = {24'h0, lid_reg[7:0]};
            filt0_off: rd_mux = filt_reg[0];
            filt1_off: rd_mux = filt_reg[1];
            default: rd_mux = 32'h0000_0000;
        endcase
        for (int i = 0; i < 3; i++) begin
            if (bsr_rel == 8'(i * 4)) begin
                rd_mux = {id_reg[i], 11'h0, idx_reg[i], job_reg[i],
                    busy_reg[i], pend_reg[i], claim_reg[i]};
            end
            if (ldb_rel == 8'(i * 4)) begin
                rd_mux = {24'h0, byte_reg[i]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bus slave registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            acc_addr_reg <= 8'h00;
            hrdata_reg <= 32'h0000_0000;
        end else begin
            wr_pend_reg <= addr_ok && hwrite;
            rd_pend_reg <= addr_ok && !hwrite;
            if (addr_ok) begin
                acc_addr_reg <= haddr[7:0];
            end
            if (rd_pend_reg) begin
                hrdata_reg <= rd_mux;
            end
        end
    end

    // control, enables, filters, flags, last identifier
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= ctrl_rst;
            icr_reg <= icr_rst;
            isr_reg <= 4'h0;
            lid_reg <= 16'h0000;
            filt_reg[0] <= filt_rst;
            filt_reg[1] <= filt_rst;
        end else begin
            if (ctrl_wr) ctrl_reg <= hwdata[3:0];
            if (icr_wr) icr_reg <= hwdata[3:0];
            if (filt0_wr) filt_reg[0] <= hwdata;
            if (filt1_wr) filt_reg[1] <= hwdata;
            isr_reg <= isr_next;
            // every accepted identifier overwrites, dropped ones too
            if (rx_take) lid_reg <= evt.rx_id; // see R17
        end
    end

    // buffer status and contents
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            claim_reg <= 3'h0;
            pend_reg <= 3'h0;
            job_reg <= 3'h0;
            busy_reg <= 3'h0;
            idx_reg <= 3'h0;
            for (int i = 0; i < 3; i++) begin
                id_reg[i] <= 16'h0000;
                byte_reg[i] <= 8'h00;
            end
        end else begin
            claim_reg <= claim_next;
            pend_reg <= pend_next;
            job_reg <= job_next;
            busy_reg <= busy_next;
            idx_reg <= idx_next;
            id_reg <= id_next;
            byte_reg <= byte_next;
        end
    end

    // scheduler state and recessive-run counters
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= st_resync;
            cur_reg <= 2'd0;
            run_reg <= 4'h0;
            seq_reg <= 8'h00;
            boff_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (tx_start) cur_reg <= tx_sel;
            // bus-off remembered until resync completes
            if (evt.bus_off) begin
                boff_reg <= 1'b1;
            end else if (state_reg == st_resync && state_next == st_idle) begin
                boff_reg <= 1'b0;
            end
            if (state_reg != st_resync || lose_sync) begin
                run_reg <= 4'h0;
                seq_reg <= 8'h00;
            end else if (evt.bit_tick) begin
                // a dominant bit restarts the current run only
                if (!evt.bit_recessive || run_full) begin
                    run_reg <= 4'h0;
                end else begin
                    run_reg <= run_reg + 4'd1;
                end
                if (run_full) seq_reg <= seq_reg + 8'd1; // see R1
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // engine request; tx level stands until the result pulse
    assign req.tx_req = in_tx;
    assign req.tx_buf = cur_reg;
    assign req.tx_id = id_reg[cur_reg];
    assign req.tx_byte = byte_reg[cur_reg];
    assign req.synced = synced;
endmodule : can_buffer_scheduler

`default_nettype wire

//--- dv/can_sched_properties.sv
// port checker for the can buffer scheduler
// assumes one hclk domain; bound onto the design top
`timescale 1ns/100ps
`default_nettype none
module can_sched_properties (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire can_sched_pkg::engine_evt_t evt,
    input wire can_sched_pkg::engine_req_t req
);
    import can_sched_pkg::*;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // taken transfer, result pulse, completed recessive sample
    wire take = hsel && htrans[1] && hready;
    wire done = evt.tx_ok || evt.tx_fail;
    wire rec_tick = evt.bit_tick && evt.bit_recessive;
    sequence s_one_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence s_held;
        req.tx_req ##1 req.tx_req;
    endsequence
    property p_read_wait;
        take && !hwrite |=> s_one_wait;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read not one wait");
    property p_write_ready;
        take && hwrite |=> hreadyout;
    endproperty
    a_write_ready: assert property (p_write_ready) else $error("write stalled");
    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_sync_cause;
        $rose(req.synced) |-> $past(rec_tick);
    endproperty
    a_sync_cause: assert property (p_sync_cause)
        else $error("synced without a recessive bit");
    property p_standby;
        evt.standby |=> !req.synced && !req.tx_req;
    endproperty
    a_standby: assert property (p_standby)
        else $error("standby did not force resync");
    property p_bus_off;
        evt.bus_off |=> !req.synced && !req.tx_req;
    endproperty
    a_bus_off: assert property (p_bus_off)
        else $error("bus-off did not stop the job");
    property p_tx_synced;
        req.tx_req |-> req.synced;
    endproperty
    a_tx_synced: assert property (p_tx_synced)
        else $error("transmit request while not synced");
    property p_result_ends;
        req.tx_req && done |=> !req.tx_req;
    endproperty
    a_result_ends: assert property (p_result_ends)
        else $error("request outlived its result");
    property p_buf_stable;
        s_held |-> $stable(req.tx_buf);
    endproperty
    a_buf_stable: assert property (p_buf_stable)
        else $error("buffer changed mid transmission");
endmodule : can_sched_properties

bind can_buffer_scheduler can_sched_properties u_can_sched_properties (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .evt(evt), .req(req)
);
`default_nettype wire

//--- dv/can_bus_node.sv
// behavioural far side: bus bit samples, frames, transmit results
// assumes each task is called just after a rising hclk edge
`timescale 1ns/100ps
`default_nettype none
module can_bus_node (
    input wire logic hclk,
    input wire can_sched_pkg::engine_req_t req,
    output var can_sched_pkg::engine_evt_t evt
);
    import can_sched_pkg::*;
    // quiet bus at time zero
    initial evt = '0;
    // runs of eleven recessive bits, one per cycle, then one quiet edge
    task automatic runs(input int n);
        evt.bit_recessive <= 1'b1;
        repeat (n * 11) begin
            evt.bit_tick <= 1'b1;
            @(posedge hclk);
        end
        evt.bit_tick <= 1'b0;
        evt.bit_recessive <= 1'b0;
        @(posedge hclk);
    endtask : runs
    task automatic level(input logic v);
        evt.standby <= v;
        @(posedge hclk);
    endtask : level
    task automatic drop_off;
        evt.bus_off <= 1'b1;
        @(posedge hclk);
        evt.bus_off <= 1'b0;
    endtask : drop_off
    // foreign frame: start pulse, n busy cycles, end pulse
    task automatic frame(input int n);
        evt.sof_seen <= 1'b1;
        @(posedge hclk);
        evt.sof_seen <= 1'b0;
        repeat (n) @(posedge hclk);
        evt.frame_end <= 1'b1;
        @(posedge hclk);
        evt.frame_end <= 1'b0;
    endtask : frame
    // id is scrambled once the frame passed, so stale ids never match
    task automatic rx(input logic [15:0] id, input logic own);
        evt.rx_valid <= 1'b1;
        evt.rx_id <= id;
        evt.rx_own <= own;
        @(posedge hclk);
        evt.rx_valid <= 1'b0;
        evt.rx_id <= ~id;
    endtask : rx
    // answers only a standing request, after a chosen stall
    task automatic result(input logic ok, input int dly);
        while (req.tx_req !== 1'b1) @(posedge hclk);
        repeat (dly) @(posedge hclk);
        evt.tx_ok <= ok;
        evt.tx_fail <= ~ok;
        @(posedge hclk);
        evt.tx_ok <= 1'b0;
        evt.tx_fail <= 1'b0;
    endtask : result
endmodule : can_bus_node
`default_nettype wire

//--- dv/tb_can_buffer_scheduler.sv
// self-checking bench: ahb-lite register access plus bus node model
// assumes the checker is bound onto the design by its own file
`timescale 1ns/100ps
`default_nettype none
module tb_can_buffer_scheduler;
    import can_sched_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    engine_evt_t evt;
    engine_req_t req;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;

    can_buffer_scheduler u_can_buffer_scheduler (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .evt(evt), .req(req), .irq(irq)
    );
    can_bus_node u_can_bus_node (.hclk(hclk), .req(req), .evt(evt));

    ////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : check
    // one single transfer; waits on hready, no cycle count assumed
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        check(rd & m, e);
    endtask : rdc
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    // hang guard, well above the ~3000 cycles the run needs
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            mismatches++;
            close_out();
        end
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check({29'h0, hreadyout, irq, req.synced}, 32'h4);
        rdc(ctrl_off, '1, 32'h0);
        wr(8'hfc, 32'hffff_ffff);
        rdc(8'hfc, '1, 32'h0);
        $display("reset test done");
        // slow resync: one run short must not sync
        wr(ctrl_off, 32'h1);
        u_can_bus_node.runs(127);
        check({31'h0, req.synced}, 32'h0);
        u_can_bus_node.runs(1);
        check({31'h0, req.synced}, 32'h1);
        rdc(ctrl_off, 32'h10, 32'h10);
        u_can_bus_node.level(1'b1);
        @(posedge hclk);
        check({31'h0, req.synced}, 32'h0);
        wr(ctrl_off, 32'h3);
        u_can_bus_node.level(1'b0);
        u_can_bus_node.runs(1);
        check({31'h0, req.synced}, 32'h1);
        // after bus-off the fast bit no longer shortens resync
        u_can_bus_node.drop_off();
        @(posedge hclk);
        check({31'h0, req.synced}, 32'h0);
        u_can_bus_node.runs(1);
        check({31'h0, req.synced}, 32'h0);
        u_can_bus_node.runs(127);
        check({31'h0, req.synced}, 32'h1);
        $display("resync test done");
        // fill all three buffers, then overrun
        wr(filt0_off, 32'hffff_0123);
        wr(filt1_off, 32'hff00_4500);
        wr(icr_off, 32'hc);
        wr(ctrl_off, 32'h1);
        u_can_bus_node.rx(16'h0123, 1'b0);
        rdc(bsr_base_off, '1, 32'h0123_0002);
        check({31'h0, irq}, 32'h1);
        u_can_bus_node.rx(16'h4567, 1'b0);
        rdc(bsr_base_off + 8'h04, '1, 32'h4567_0012);
        u_can_bus_node.rx(16'h45aa, 1'b0);
        rdc(bsr_base_off + 8'h08, '1, 32'h45aa_0012);
        u_can_bus_node.rx(16'h4501, 1'b0);
        rdc(isr_off, '1, 32'hc);
        rdc(lid_hi_off, '1, 32'h45);
        rdc(lid_lo_off, '1, 32'h01);
        wr(bsr_base_off, 32'h2);
        u_can_bus_node.rx(16'h7777, 1'b0);
        rdc(bsr_base_off, '1, 32'h0);
        rdc(lid_lo_off, '1, 32'h77);
        u_can_bus_node.rx(16'h0123, 1'b1);
        rdc(bsr_base_off, '1, 32'h0);
        wr(ctrl_off, 32'h9);
        u_can_bus_node.rx(16'h0123, 1'b1);
        rdc(bsr_base_off, '1, 32'h0123_0002);
        $display("receive test done");
        // two jobs: buffer 1 starts first and fails once, then buffer 3 wins and finishes
        wr(isr_off, 32'hf);
        wr(icr_off, 32'h3);
        wr(ctrl_off, 32'h1);
        for (int i = 0; i < 3; i++) wr(bsr_base_off + 8'(4 * i), 32'h2);
        wr(bsr_base_off, 32'h1111_0001);
        rdc(bsr_base_off, 32'hffff_0001, 32'h1111_0001);
        wr(bsr_base_off + 8'h08, 32'h3333_0001);
        wr(ldb_base_off, 32'haa);
        wr(ldb_base_off + 8'h08, 32'hbb);
        u_can_bus_node.result(1'b0, 0);
        rdc(isr_off, 32'h3, 32'h2);
        while (req.tx_req !== 1'b1) @(posedge hclk);
        check({30'h0, req.tx_buf}, 32'h2);
        check({8'h0, req.tx_id, req.tx_byte}, 32'h3333bb);
        rdc(bsr_base_off + 8'h08, 32'h6, 32'h6);
        u_can_bus_node.result(1'b1, 3);
        rdc(bsr_base_off + 8'h08, 32'h6, 32'h0);
        rdc(isr_off, 32'h3, 32'h3);
        check({31'h0, irq}, 32'h1);
        while (req.tx_req !== 1'b1) @(posedge hclk);
        check({30'h0, req.tx_buf}, 32'h0);
        rdc(bsr_base_off, 32'h6, 32'h6);
        u_can_bus_node.result(1'b1, 1);
        // no-retransmit: one failed attempt ends the job
        wr(ctrl_off, 32'h5);
        wr(ldb_base_off, 32'h55);
        u_can_bus_node.result(1'b0, 2);
        repeat (3) @(posedge hclk);
        check({31'h0, req.tx_req}, 32'h0);
        rdc(bsr_base_off, 32'h6, 32'h0);
        fork
            u_can_bus_node.frame(8);
            wr(ldb_base_off, 32'h66);
        join
        check({31'h0, req.tx_req}, 32'h0);
        repeat (2) @(posedge hclk);
        check({31'h0, req.tx_req}, 32'h1);
        $display("transmit test done");
        close_out();
    end
endmodule : tb_can_buffer_scheduler
`default_nettype wire
